// ==== pkg/adcseq_regs.vh ====
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH
// converter clock cycles per conversion
`define ADCSEQ_NORM_CYCLES 5'd13
`define ADCSEQ_EXT_CYCLES 5'd25
// sample instant, whole converter cycles after start (plus half cycle)
`define ADCSEQ_NORM_SAMPLE 5'd1
`define ADCSEQ_EXT_SAMPLE 5'd13
// lowest system clock the prescaler serves, kHz
`define ADCSEQ_MIN_SYSCLK_KHZ 100
// selection widths and reset values
`define ADCSEQ_CHAN_W 5
`define ADCSEQ_REF_W 2
`define ADCSEQ_CHAN_RST 5'h00
`define ADCSEQ_REF_RST 2'h0
// first differential channel code, last differential code
`define ADCSEQ_DIFF_FIRST 5'h0b
`define ADCSEQ_DIFF_LAST 5'h1a
// result code limits
`define ADCSEQ_CODE_MAX 10'h3ff
`define ADCSEQ_CODE_MIN 10'h000
`endif

// ==== design/adcseq_prescaler.v ====
`timescale 1ns/1ps
`default_nettype none
module adcseq_prescaler (
  // clock and reset
  input wire clk,
  input wire nrst,
  // control
  input wire enable,
  input wire [2:0] divide_select,
  // converter clock edges
  output reg rise_pulse,
  output reg fall_pulse
);
  reg [7:0] count_reg;
  reg [7:0] count_next;
  wire [7:0] half;
  wire [7:0] top;
  // power-of-two ratio 2..256
  assign half = 8'h01 << divide_select;
  assign top = half | (half - 8'h01);
  // wrap also when a smaller ratio is picked mid-count
  always @* begin
    count_next = (count_reg >= top) ? 8'h00 : count_reg + 8'h01;
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 8'h00;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else if (!enable) begin
      count_reg <= 8'h00;
      rise_pulse <= 1'b0;
      fall_pulse <= 1'b0;
    end else begin
      count_reg <= count_next;
      rise_pulse <= (count_next == 8'h00);
      fall_pulse <= (count_next == half);
    end
  end
endmodule
`default_nettype wire

// ==== design/adcseq_core.v ====
`include "adcseq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module adcseq_core (
  // clock and reset
  input wire clk,
  input wire nrst,
  // control bits
  input wire converter_on,
  input wire convert_go_set,
  input wire free_run_select,
  input wire [2:0] clock_divide_select,
  input wire done_irq_enable,
  input wire conv_done_flag_clr,
  input wire cpu_halted,
  // buffered selection writes
  input wire sel_write,
  input wire [4:0] channel_gain_select,
  input wire [1:0] reference_select,
  // result register reads
  input wire result_low_read,
  input wire result_high_read,
  // analog core result (already ratio-scaled, clamped by core)
  input wire [10:0] core_code,
  // status
  output reg convert_go,
  output reg conv_done_flag,
  output reg done_irq,
  output reg [9:0] result_reg,
  // analog side
  output reg [4:0] active_chan,
  output reg [1:0] active_ref,
  output reg sample_hold,
  output reg converting,
  output reg extended_conv
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;
  reg [1:0] state_reg;
  reg [4:0] buf_chan_reg;
  reg [1:0] buf_ref_reg;
  reg [4:0] cyc_reg;
  reg first_reg;
  reg parity_reg;
  reg lock_reg;
  reg sleep_arm_reg;
  reg sleep_pend_reg;
  reg halted_reg;
  wire rise;
  wire fall;
  wire diff_sel;
  wire start_ok;
  wire start_req;
  wire [4:0] last_cyc;
  wire [4:0] samp_cyc;
  wire done_now;
  wire [9:0] code_sat;

  function is_diff;
    input [4:0] ch;
    begin
      is_diff = (ch >= `ADCSEQ_DIFF_FIRST) && (ch <= `ADCSEQ_DIFF_LAST);
    end
  endfunction

  adcseq_prescaler u_presc (
    .clk(clk),
    .nrst(nrst),
    .enable(converter_on),
    .divide_select(clock_divide_select),
    .rise_pulse(rise),
    .fall_pulse(fall)
  );

  assign diff_sel = is_diff(active_chan);
  assign start_ok = rise && (!diff_sel || parity_reg);
  assign start_req = convert_go || (sleep_arm_reg && halted_reg) || sleep_pend_reg;
  assign last_cyc = first_reg ? `ADCSEQ_EXT_CYCLES : `ADCSEQ_NORM_CYCLES;
  assign samp_cyc = first_reg ? `ADCSEQ_EXT_SAMPLE : `ADCSEQ_NORM_SAMPLE;
  assign done_now = (state_reg == ST_CONV) && rise && (cyc_reg == last_cyc);
  assign code_sat = core_code[10] ? `ADCSEQ_CODE_MAX : core_code[9:0];

  // edge parity counted from enable
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      parity_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      halted_reg <= cpu_halted;
      if (!converter_on)
        parity_reg <= 1'b0;
      else if (rise)
        parity_reg <= ~parity_reg;
    end
  end

  // sleep arming
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_arm_reg <= 1'b0;
      sleep_pend_reg <= 1'b0;
    end else begin
      sleep_arm_reg <= converter_on && !convert_go && !free_run_select &&
        done_irq_enable && (state_reg == ST_IDLE) && !halted_reg;
      // halt seen, request held until start, halt release or converter off
      if (!converter_on || !halted_reg || (state_reg != ST_IDLE))
        sleep_pend_reg <= 1'b0;
      else if (sleep_arm_reg)
        sleep_pend_reg <= 1'b1;
    end
  end

  // selection buffer and active copy
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      buf_chan_reg <= `ADCSEQ_CHAN_RST;
      buf_ref_reg <= `ADCSEQ_REF_RST;
      active_chan <= `ADCSEQ_CHAN_RST;
      active_ref <= `ADCSEQ_REF_RST;
    end else begin
      if (sel_write) begin
        buf_chan_reg <= channel_gain_select;
        buf_ref_reg <= reference_select;
      end
      if (!lock_reg) begin
        active_chan <= buf_chan_reg;
        active_ref <= buf_ref_reg;
      end
    end
  end

  // conversion sequencer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 5'h00;
      first_reg <= 1'b1;
      lock_reg <= 1'b0;
      convert_go <= 1'b0;
      sample_hold <= 1'b0;
      converting <= 1'b0;
      extended_conv <= 1'b0;
    end else if (!converter_on) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 5'h00;
      first_reg <= 1'b1;
      lock_reg <= 1'b0;
      convert_go <= convert_go_set;
      sample_hold <= 1'b0;
      converting <= 1'b0;
      extended_conv <= 1'b0;
    end else begin
      if (convert_go_set)
        convert_go <= 1'b1;
      sample_hold <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_req && start_ok) begin
            state_reg <= ST_CONV;
            cyc_reg <= 5'h01;
            lock_reg <= 1'b1;
            converting <= 1'b1;
            extended_conv <= first_reg;
            convert_go <= 1'b1;
          end
        end
        ST_CONV: begin
          // sample on falling edge after whole cycles
          if (fall && (cyc_reg == samp_cyc + 5'h01))
            sample_hold <= 1'b1;
          if (rise) begin
            cyc_reg <= cyc_reg + 5'h01;
            if (cyc_reg == last_cyc - 5'h01)
              lock_reg <= 1'b0;
          end
          if (done_now) begin
            first_reg <= 1'b0;
            extended_conv <= 1'b0;
            if (free_run_select) begin
              cyc_reg <= 5'h01;
              lock_reg <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
              cyc_reg <= 5'h00;
              converting <= 1'b0;
              convert_go <= convert_go_set;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // results, flag and interrupt
  reg rd_lock_reg;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_reg <= `ADCSEQ_CODE_MIN;
      conv_done_flag <= 1'b0;
      rd_lock_reg <= 1'b0;
      done_irq <= 1'b0;
    end else begin
      // low read locks, high read unlocks
      if (result_low_read)
        rd_lock_reg <= 1'b1;
      else if (result_high_read)
        rd_lock_reg <= 1'b0;
      if (done_now && !rd_lock_reg && !result_low_read)
        result_reg <= code_sat;
      // set wins over clear
      if (done_now)
        conv_done_flag <= 1'b1;
      else if (conv_done_flag_clr)
        conv_done_flag <= 1'b0;
      done_irq <= done_irq_enable && (conv_done_flag || done_now) &&
        !(conv_done_flag_clr && !done_now);
    end
  end
endmodule
`default_nettype wire

// ==== sim/adcseq_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcseq_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // controls
  input wire logic converter_on,
  input wire logic free_run_select,
  input wire logic done_irq_enable,
  // outputs watched
  input wire logic convert_go,
  input wire logic conv_done_flag,
  input wire logic done_irq,
  input wire logic [9:0] result_reg,
  input wire logic [4:0] active_chan,
  input wire logic sample_hold,
  input wire logic converting
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_off; !converter_on [*3] |-> !converting; endproperty
  a_off: assert property (p_off) else $error("converting while off");
  property p_start; $rose(convert_go) |-> ##[1:600] converting; endproperty
  a_start: assert property (p_start) else $error("no start after go");
  property p_sh; sample_hold |-> converting ##1 !sample_hold; endproperty
  a_sh: assert property (p_sh) else $error("bad sample pulse");
  property p_go_clr; $rose(conv_done_flag) && !free_run_select |-> !convert_go; endproperty
  a_go_clr: assert property (p_go_clr) else $error("go not cleared");
  property p_res; $changed(result_reg) |-> conv_done_flag; endproperty
  a_res: assert property (p_res) else $error("result moved without flag");
  property p_frun; $rose(conv_done_flag) && free_run_select |-> convert_go; endproperty
  a_frun: assert property (p_frun) else $error("go dropped in free run");
  property p_frz; $rose(converting) |=> $stable(active_chan) [*8]; endproperty
  a_frz: assert property (p_frz) else $error("selection not frozen");
  property p_irq; conv_done_flag && done_irq_enable |-> ##[0:1] done_irq; endproperty
  a_irq: assert property (p_irq) else $error("no completion irq");
  c_done: cover property ($rose(conv_done_flag));
  c_sh: cover property (sample_hold);
  c_frun: cover property ($rose(conv_done_flag) && free_run_select);
endmodule
bind adcseq_core adcseq_asserts chk_i (
  .clk(clk),
  .nrst(nrst),
  .converter_on(converter_on),
  .free_run_select(free_run_select),
  .done_irq_enable(done_irq_enable),
  .convert_go(convert_go),
  .conv_done_flag(conv_done_flag),
  .done_irq(done_irq),
  .result_reg(result_reg),
  .active_chan(active_chan),
  .sample_hold(sample_hold),
  .converting(converting)
);
`default_nettype wire

// ==== sim/adcseq_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcseq_analog_model #(parameter int VREF_MV = 2560) (
  // converter side
  input wire logic clk,
  input wire logic sample_hold,
  input wire logic [4:0] active_chan,
  // test voltages
  input var int vpos_mv,
  input var int vneg_mv,
  input var int gain,
  // code out
  output logic [10:0] core_code
);
  int v;
  always @(posedge clk)
    if (sample_hold) begin
      if (active_chan < 5'h0b || active_chan > 5'h1a)
        v = vpos_mv * 1024 / VREF_MV;
      else
        v = (vpos_mv - vneg_mv) * gain * 1024 / VREF_MV;
      core_code <= v < 0 ? 11'h000 : v > 1023 ? 11'h400 : v[10:0];
    end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 0, nrst = 0, converter_on = 0, convert_go_set = 0, free_run_select = 0;
  logic done_irq_enable = 0, conv_done_flag_clr = 0, cpu_halted = 0, sel_write = 0;
  logic result_low_read = 0, result_high_read = 0;
  logic [2:0] clock_divide_select = 3'h0;
  logic [4:0] channel_gain_select = 5'h00;
  logic [1:0] reference_select = 2'h0;
  logic [10:0] core_code;
  logic convert_go, conv_done_flag, done_irq, sample_hold, converting, extended_conv;
  logic [9:0] result_reg;
  logic [4:0] active_chan;
  logic [1:0] active_ref;
  int vpos_mv = 1000, vneg_mv = 0, gain = 1, mismatches = 0, compares = 0, ncyc = 0, tick = 0;
  int n0 = 0, on_cyc = 0, start_at = 0;
  logic conv_q = 0;
  adcseq_core dut (
    .clk(clk),
    .nrst(nrst),
    .converter_on(converter_on),
    .convert_go_set(convert_go_set),
    .free_run_select(free_run_select),
    .clock_divide_select(clock_divide_select),
    .done_irq_enable(done_irq_enable),
    .conv_done_flag_clr(conv_done_flag_clr),
    .cpu_halted(cpu_halted),
    .sel_write(sel_write),
    .channel_gain_select(channel_gain_select),
    .reference_select(reference_select),
    .result_low_read(result_low_read),
    .result_high_read(result_high_read),
    .core_code(core_code),
    .convert_go(convert_go),
    .conv_done_flag(conv_done_flag),
    .done_irq(done_irq),
    .result_reg(result_reg),
    .active_chan(active_chan),
    .active_ref(active_ref),
    .sample_hold(sample_hold),
    .converting(converting),
    .extended_conv(extended_conv)
  );
  adcseq_analog_model ana (
    .clk(clk),
    .sample_hold(sample_hold),
    .active_chan(active_chan),
    .vpos_mv(vpos_mv),
    .vneg_mv(vneg_mv),
    .gain(gain),
    .core_code(core_code)
  );
  initial forever #4 clk = ~clk;
  // clock edges from enable to the latest conversion start
  always @(posedge clk) begin
    on_cyc <= converter_on ? on_cyc + 1 : 0;
    conv_q <= converting;
    if (converting && !conv_q)
      start_at <= on_cyc;
  end
  always @(posedge clk) begin
    tick <= tick + 1;
    if (converting)
      ncyc <= ncyc + 1;
    if (tick == 40000) begin
      mismatches++;
      give_verdict;
    end
  end
  task give_verdict;
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clk) s = 0;
  endtask
  task wait_done;
    repeat (4000) if (!conv_done_flag) @(negedge clk);
  endtask
  // one single conversion, length and go checked
  task conv(input logic [15:0] len);
    n0 = ncyc;
    pulse(convert_go_set);
    wait_done;
    chk(ncyc - n0, len);
    chk(convert_go, 16'h0);
    pulse(conv_done_flag_clr);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1;
    converter_on = 1;
    conv(16'h32);
    chk(result_reg, 16'h190);
    for (int s = 0; s < 3; s++) begin
      clock_divide_select = s[2:0];
      conv(16'h0d << (s + 1));
    end
    // slowest ratio, converter clock within the reduced-resolution range
    clock_divide_select = 3'h7;
    conv(16'hd00);
    clock_divide_select = 3'h0;
    pulse(convert_go_set);
    repeat (6) @(negedge clk);
    channel_gain_select = 5'h03;
    pulse(sel_write);
    chk(active_chan, 16'h0);
    wait_done;
    chk(active_chan, 16'h3);
    pulse(conv_done_flag_clr);
    channel_gain_select = 5'h0b;
    reference_select = 2'h3;
    pulse(sel_write);
    @(negedge clk);
    chk(active_chan, 16'h0b);
    // gain stage settling after new differential channel and reference
    repeat (15625) @(negedge clk);
    vpos_mv = 400;
    vneg_mv = 300;
    gain = 20;
    conv(16'h1a);
    chk(result_reg, 16'h320);
    pulse(result_low_read);
    vpos_mv = 200;
    conv(16'h1a);
    chk(result_reg, 16'h320);
    pulse(result_high_read);
    conv(16'h1a);
    chk(result_reg, 16'h000);
    free_run_select = 1;
    pulse(convert_go_set);
    repeat (80) @(negedge clk);
    chk(convert_go, 16'h1);
    chk(conv_done_flag, 16'h1);
    converter_on = 0;
    free_run_select = 0;
    repeat (4) @(negedge clk);
    chk(converting, 16'h0);
    pulse(conv_done_flag_clr);
    converter_on = 1;
    done_irq_enable = 1;
    cpu_halted = 1;
    wait_done;
    @(negedge clk);
    chk(conv_done_flag, 16'h1);
    chk(done_irq, 16'h1);
    chk(start_at % 4, 16'h1);
    give_verdict;
  end
endmodule
`default_nettype wire
